// ==== rtl/hsa_pkg.sv ====
// constants, layouts and types of the health status aggregator
// assumes one clock domain; every word is 16 bits wide
package hsa_pkg;
  localparam int WORD_W = 16;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // global health word bit positions
  localparam int GH_FATAL = 0;
  localparam int GH_HW_ERR = 1;
  localparam int GH_LINK_ERR = 2;
  localparam int GH_SW_ERR = 3;
  localparam int GH_ALERT = 8;
  localparam int GH_HW_ALERT = 9;
  localparam int GH_LINK_ALERT = 10;
  localparam int GH_SW_ALERT = 11;
  localparam int GH_SENSE_ALERT = 12;
  // category and leaf word bit positions
  localparam int HW_SUPPLY = 0;
  localparam int HW_AMBIENT = 1;
  localparam int LINK_USER = 0;
  localparam int LINK_AIDING = 1;
  localparam int SW_ALGO = 0;
  localparam int SW_DATA = 1;
  localparam int DATA_CAL = 0;
  localparam int DATA_MAG = 1;
  localparam int COND_CAL_STORE = 3;
  // leaf flag counts
  localparam int POWER_FLAGS = 9;
  localparam int PORT_FLAGS = 5;
  localparam int ALGO_FLAGS = 3;
  localparam int COND_FLAGS = 3;
  // implemented bits of each word, reserved bits are zero
  localparam logic [15:0] GH_VALID = 16'h1f0f;
  localparam logic [15:0] PAIR_VALID = 16'h0003;
  localparam logic [15:0] POWER_VALID = 16'h01ff;
  localparam logic [15:0] AMBIENT_VALID = 16'h0001;
  localparam logic [15:0] PORT_VALID = 16'h001f;
  localparam logic [15:0] ALGO_VALID = 16'h0007;
  localparam logic [15:0] COND_VALID = 16'h000f;
  // field identifiers on the read port
  localparam logic [15:0] FID_GLOBAL = 16'h0100;
  localparam logic [15:0] FID_HW = 16'h0101;
  localparam logic [15:0] FID_POWER = 16'h0102;
  localparam logic [15:0] FID_AMBIENT = 16'h0103;
  localparam logic [15:0] FID_LINK = 16'h0104;
  localparam logic [15:0] FID_USER = 16'h0105;
  localparam logic [15:0] FID_AIDING = 16'h0106;
  localparam logic [15:0] FID_SW = 16'h0107;
  localparam logic [15:0] FID_ALGO = 16'h0108;
  localparam logic [15:0] FID_DATA = 16'h0109;
  localparam logic [15:0] FID_COND = 16'h010a;
  // persistency filter defaults
  localparam int PERSIST_CNT_W = 8;
  localparam int PERSIST_THRESHOLD = 4;
  localparam int PERSIST_LEAK_CYCLES = 1000;
  typedef enum logic [1:0] {PS_QUIET, PS_COUNT, PS_TRIP} hsa_persist_state_t;
  // keep only the implemented bits of a word
  function automatic logic [15:0] hsa_keep(input logic [15:0] v, input logic [15:0] valid);
    return v & valid;
  endfunction
endpackage

// ==== rtl/hsa_persist.sv ====
// leaky-bucket persistency filter for one soft error category
// assumes i_err_level comes from a flop in the same clock domain
`timescale 1ns/1ps
module hsa_persist #(
  parameter int CNT_W = hsa_pkg::PERSIST_CNT_W,
  parameter int THRESHOLD = hsa_pkg::PERSIST_THRESHOLD,
  parameter int LEAK_CYCLES = hsa_pkg::PERSIST_LEAK_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // error level in, trip out
  input wire logic i_err_level,
  output logic o_trip
);
  import hsa_pkg::*;
  localparam int LK_W = $clog2(LEAK_CYCLES + 1);
  localparam logic [CNT_W-1:0] THR = CNT_W'(THRESHOLD);
  localparam logic [LK_W-1:0] LK_LAST = LK_W'(LEAK_CYCLES - 1);

  if (THRESHOLD < 1 || THRESHOLD >= (2 ** CNT_W) || LEAK_CYCLES < 1) begin : g_bad
    $error("hsa_persist: threshold or leak period out of range");
  end

  logic prev;
  logic rise;
  logic leak;
  logic [LK_W-1:0] leak_cnt;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  hsa_persist_state_t state;

  assign rise = i_err_level & ~prev;
  assign leak = (leak_cnt == LK_LAST);

  // edge detect of the error level
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) prev <= 1'b0;
    else prev <= i_err_level;
  end

  // free running leak period
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) leak_cnt <= '0;
    else if (leak) leak_cnt <= '0;
    else leak_cnt <= leak_cnt + 1'b1;
  end

  // R19: high-pass occurrence count
  always_comb begin
    next_count = count;
    if (rise && !leak && count != '1) next_count = count + 1'b1;
    else if (leak && !rise && count != '0) next_count = count - 1'b1;
  end

  // R19: trip once the count reaches threshold
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      count <= '0;
      state <= PS_QUIET;
    end else begin
      count <= next_count;
      case (state)
        PS_QUIET: if (next_count >= THR) state <= PS_TRIP;
                  else if (next_count != '0) state <= PS_COUNT;
        PS_COUNT: if (next_count >= THR) state <= PS_TRIP;
                  else if (next_count == '0) state <= PS_QUIET;
        PS_TRIP: state <= PS_TRIP;
        default: state <= PS_QUIET;
      endcase
    end
  end

  assign o_trip = (state == PS_TRIP);

  chk_trip_count: assert property (@(posedge i_mclk) disable iff (i_rst)
    (count >= THR) |-> o_trip) else $error("count at threshold without trip"); // R19
endmodule // hsa_persist

// ==== rtl/hsa_top.sv ====
// health status aggregator: error and alert tree with field read port
// assumes leaf flags are synchronous levels; one host reads fields by id
`timescale 1ns/1ps
// Functional notes
// R1: fatal and error summaries in bits 0-3
// R2: alert summaries in bits 8-12
// R3: overall alert is OR of four
// R4: soft failure sets category, fatal after persistency
// R5: each alert flag gated by enable mask; code masks only the condition word, not link, sw or sensing
// R6: hardware error is OR of hardware word
// R7: supply error is OR of nine flags
// R8: ambient error is OR of temperature word
// R9: link error is OR of link word
// R10: user port error is OR of five flags
// R11: aiding port error matches user layout
// R12: software error is OR of software word
// R13: algorithm error is OR of three flags
// R14: stored data error is OR of two
// R15: checksum fail also set by compromising write
// R16: hardware alert is OR of masked conditions
// R17: condition word bits 0-2 receiver flags
// R18: condition bit 3 follows calibration store unlock
// R19: soft error fatal only if it recurs
// R20: fault pin mirrors fatal summary bit
// R21: hard failure sets fatal immediately
// R22: reserved bits zero, tree clears on reset
// R23: persistency window and threshold are parameters
module hsa_top #(
  parameter int PERSIST_CNT_W = hsa_pkg::PERSIST_CNT_W,
  parameter int PERSIST_THRESHOLD = hsa_pkg::PERSIST_THRESHOLD,
  parameter int PERSIST_LEAK_CYCLES = hsa_pkg::PERSIST_LEAK_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // hardware error leaves
  input wire logic [hsa_pkg::POWER_FLAGS-1:0] i_power_oob,
  input wire logic i_board_temp_oob,
  // serial port error leaves
  input wire logic [hsa_pkg::PORT_FLAGS-1:0] i_user_port_flags,
  input wire logic [hsa_pkg::PORT_FLAGS-1:0] i_aiding_port_flags,
  // software error leaves
  input wire logic [hsa_pkg::ALGO_FLAGS-1:0] i_algo_flags,
  input wire logic i_cal_crc_mismatch,
  input wire logic i_cal_nv_write,
  input wire logic i_cal_revalidated,
  input wire logic i_mag_align_oob,
  // hardware conditions and alert mask
  input wire logic [hsa_pkg::COND_FLAGS-1:0] i_hw_cond,
  input wire logic i_cal_store_unlocked,
  input wire logic [hsa_pkg::WORD_W-1:0] i_hw_alert_mask,
  // category alerts reduced elsewhere
  input wire logic i_link_alert_summary,
  input wire logic i_sw_alert_summary,
  input wire logic i_sensing_alert_summary,
  // field read port
  input wire logic i_field_rd,
  input wire logic [hsa_pkg::WORD_W-1:0] i_field_id,
  output logic o_field_ack,
  output logic o_field_bad,
  output logic [hsa_pkg::WORD_W-1:0] o_field_data,
  // fault pin
  output logic o_hw_fault
);
  import hsa_pkg::*;

  // leaf words
  logic [15:0] power_error_word;
  logic [15:0] environment_error_word;
  logic [15:0] user_port_error_word;
  logic [15:0] aiding_port_error_word;
  logic [15:0] algorithm_error_word;
  logic [15:0] data_error_word;
  logic [15:0] hw_condition_word;
  // category and global words
  logic [15:0] hw_error_word;
  logic [15:0] link_error_word;
  logic [15:0] sw_error_word;
  logic [15:0] global_health_word;
  // summary signals
  logic supply_err;
  logic ambient_err;
  logic user_port_err;
  logic aiding_port_err;
  logic algo_err;
  logic stored_data_err;
  logic hw_err_summary;
  logic link_err_summary;
  logic sw_err_summary;
  logic hw_alert_summary;
  logic alert_summary;
  logic fatal_summary;
  logic next_fatal;
  logic hard_any;
  logic trip_hw;
  logic trip_link;
  logic cal_compromised;
  logic [15:0] next_field_data;
  logic next_field_bad;

  // R7: supply flags captured each cycle
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) power_error_word <= WORD_RST;
    else power_error_word <= hsa_keep(16'(i_power_oob), POWER_VALID);
  end

  // R8: board temperature flag
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) environment_error_word <= WORD_RST;
    else environment_error_word <= hsa_keep(16'(i_board_temp_oob), AMBIENT_VALID);
  end

  // R10: user port flags
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) user_port_error_word <= WORD_RST;
    else user_port_error_word <= hsa_keep(16'(i_user_port_flags), PORT_VALID);
  end

  // R11: aiding port flags, same layout
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) aiding_port_error_word <= WORD_RST;
    else aiding_port_error_word <= hsa_keep(16'(i_aiding_port_flags), PORT_VALID);
  end

  // R13: algorithm flags
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) algorithm_error_word <= WORD_RST;
    else algorithm_error_word <= hsa_keep(16'(i_algo_flags), ALGO_VALID);
  end

  // R15: compromise latch, a write wins over revalidation
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) cal_compromised <= 1'b0;
    else if (i_cal_nv_write) cal_compromised <= 1'b1;
    else if (i_cal_revalidated) cal_compromised <= 1'b0;
  end

  // R14: stored data flags, checksum bit folds in the compromise
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      data_error_word <= WORD_RST;
    end else begin
      data_error_word <= WORD_RST;
      data_error_word[DATA_CAL] <= i_cal_crc_mismatch | i_cal_nv_write
                                   | (cal_compromised & ~i_cal_revalidated);
      data_error_word[DATA_MAG] <= i_mag_align_oob;
    end
  end

  // R17: receiver conditions, R18 store unlock in bit 3
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      hw_condition_word <= WORD_RST;
    end else begin
      hw_condition_word <= hsa_keep(16'(i_hw_cond), COND_VALID);
      hw_condition_word[COND_CAL_STORE] <= i_cal_store_unlocked;
    end
  end

  // R7: supply error reduction
  assign supply_err = |power_error_word;
  // R8: ambient error reduction
  assign ambient_err = |environment_error_word;
  // R10: user port reduction
  assign user_port_err = |user_port_error_word;
  // R11: aiding port reduction
  assign aiding_port_err = |aiding_port_error_word;
  // R13: algorithm reduction
  assign algo_err = |algorithm_error_word;
  // R14: stored data reduction
  assign stored_data_err = |data_error_word;

  // R6: hardware error word and summary
  always_comb begin
    hw_error_word = WORD_RST;
    hw_error_word[HW_SUPPLY] = supply_err;
    hw_error_word[HW_AMBIENT] = ambient_err;
  end
  assign hw_err_summary = |hw_error_word;

  // R9: link error word and summary
  always_comb begin
    link_error_word = WORD_RST;
    link_error_word[LINK_USER] = user_port_err;
    link_error_word[LINK_AIDING] = aiding_port_err;
  end
  assign link_err_summary = |link_error_word;

  // R12: software error word and summary
  always_comb begin
    sw_error_word = WORD_RST;
    sw_error_word[SW_ALGO] = algo_err;
    sw_error_word[SW_DATA] = stored_data_err;
  end
  assign sw_err_summary = |sw_error_word;

  // R16: masked condition reduction, R5 per-flag enable
  assign hw_alert_summary = |(hw_condition_word & i_hw_alert_mask);
  // R3: overall alert from the four categories
  assign alert_summary = hw_alert_summary | i_link_alert_summary
                         | i_sw_alert_summary | i_sensing_alert_summary;

  // R23: persistency filters sized by parameters
  hsa_persist #(
    .CNT_W(PERSIST_CNT_W),
    .THRESHOLD(PERSIST_THRESHOLD),
    .LEAK_CYCLES(PERSIST_LEAK_CYCLES)
  ) u_persist_hw (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_err_level(hw_err_summary),
    .o_trip(trip_hw)
  );

  hsa_persist #(
    .CNT_W(PERSIST_CNT_W),
    .THRESHOLD(PERSIST_THRESHOLD),
    .LEAK_CYCLES(PERSIST_LEAK_CYCLES)
  ) u_persist_link (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_err_level(link_err_summary),
    .o_trip(trip_link)
  );

  // R21: hard categories bypass the filter
  assign hard_any = sw_err_summary;
  // R4: soft errors reach fatal only through a trip
  assign next_fatal = fatal_summary | hard_any | trip_hw | trip_link;

  // fatal summary holds until reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) fatal_summary <= 1'b0;
    else fatal_summary <= next_fatal;
  end

  // R20: fault pin is the fatal flop itself
  assign o_hw_fault = fatal_summary;

  // R1: error half, R2 alert half, R22 reserved zero
  always_comb begin
    global_health_word = WORD_RST;
    global_health_word[GH_FATAL] = fatal_summary;
    global_health_word[GH_HW_ERR] = hw_err_summary;
    global_health_word[GH_LINK_ERR] = link_err_summary;
    global_health_word[GH_SW_ERR] = sw_err_summary;
    global_health_word[GH_ALERT] = alert_summary;
    global_health_word[GH_HW_ALERT] = hw_alert_summary;
    global_health_word[GH_LINK_ALERT] = i_link_alert_summary;
    global_health_word[GH_SW_ALERT] = i_sw_alert_summary;
    global_health_word[GH_SENSE_ALERT] = i_sensing_alert_summary;
    global_health_word = hsa_keep(global_health_word, GH_VALID);
  end

  // field select by identifier
  always_comb begin
    next_field_bad = 1'b0;
    case (i_field_id)
      FID_GLOBAL: next_field_data = global_health_word;
      FID_HW: next_field_data = hw_error_word;
      FID_POWER: next_field_data = power_error_word;
      FID_AMBIENT: next_field_data = environment_error_word;
      FID_LINK: next_field_data = link_error_word;
      FID_USER: next_field_data = user_port_error_word;
      FID_AIDING: next_field_data = aiding_port_error_word;
      FID_SW: next_field_data = sw_error_word;
      FID_ALGO: next_field_data = algorithm_error_word;
      FID_DATA: next_field_data = data_error_word;
      FID_COND: next_field_data = hw_condition_word;
      default: begin
        next_field_data = WORD_RST;
        next_field_bad = 1'b1;
      end
    endcase
  end

  // read answer one cycle after the request
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_field_ack <= 1'b0;
      o_field_bad <= 1'b0;
      o_field_data <= WORD_RST;
    end else begin
      o_field_ack <= i_field_rd;
      if (i_field_rd) begin
        o_field_bad <= next_field_bad;
        o_field_data <= next_field_data;
      end
    end
  end

  // checks on the aggregation tree
  // R20: pin agrees with the fatal bit that a global read returns
  chk_fault_pin_mirror: assert property (@(posedge i_mclk) disable iff (i_rst) // R20
    o_field_ack && $past(i_field_id) == FID_GLOBAL
    |-> o_field_data[GH_FATAL] == $past(o_hw_fault))
    else $error("fault pin differs from fatal bit");

  // R3: overall alert is OR of categories
  chk_alert_or_tree: assert property (@(posedge i_mclk) disable iff (i_rst) // R3
    global_health_word[GH_ALERT] == |global_health_word[GH_SENSE_ALERT:GH_HW_ALERT])
    else $error("overall alert not the OR of categories");

  // R21: hard input is fatal two edges later
  chk_hard_fatal_fast: assert property (@(posedge i_mclk) disable iff (i_rst) // R21
    (|i_algo_flags || i_mag_align_oob) |-> ##2 o_hw_fault)
    else $error("hard failure did not reach fatal in time");

  // R22: reserved global bits stay zero
  chk_reserved_zero: assert property (@(posedge i_mclk) disable iff (i_rst) // R22
    (global_health_word & ~GH_VALID) == 16'h0000) else $error("reserved bit set");

  // R4: fatal rises only from a hard error or a trip
  chk_soft_needs_trip: assert property (@(posedge i_mclk) disable iff (i_rst) // R4
    $rose(fatal_summary) |-> $past(hard_any) || $past(trip_hw) || $past(trip_link))
    else $error("fatal set without hard error or trip");

  // R15: compromising write flags the checksum
  chk_cal_compromise: assert property (@(posedge i_mclk) disable iff (i_rst) // R15
    i_cal_nv_write |=> data_error_word[DATA_CAL] && global_health_word[GH_SW_ERR])
    else $error("nonvolatile write did not flag checksum");

  // R5: masked conditions raise no hardware alert
  chk_alert_gated: assert property (@(posedge i_mclk) disable iff (i_rst) // R5
    ((hw_condition_word & i_hw_alert_mask) == 16'h0000) |-> !global_health_word[GH_HW_ALERT])
    else $error("hardware alert raised by a masked flag");

  // R10: user port flag shows in link error two levels up
  chk_user_port_path: assert property (@(posedge i_mclk) disable iff (i_rst) // R10
    |i_user_port_flags |=> global_health_word[GH_LINK_ERR] && link_error_word[LINK_USER])
    else $error("user port flag lost in tree");

  // R18: condition bit 3 tracks store unlock
  chk_store_unlock: assert property (@(posedge i_mclk) disable iff (i_rst) // R18
    hw_condition_word[COND_CAL_STORE] == $past(i_cal_store_unlocked))
    else $error("store unlock bit wrong");

  // global read answers in the next cycle with the bad flag clear
  chk_field_answer: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_field_rd && i_field_id == FID_GLOBAL |=> o_field_ack && !o_field_bad)
    else $error("field read not answered");
endmodule // hsa_top

// ==== verification/hsa_host_model.sv ====
// host model that reads status fields from the aggregator by id
// assumes it shares the device clock and reads only after reset release
`timescale 1ns/1ps
module hsa_host_model (
  // clock
  input wire logic i_mclk,
  // read request towards the device
  output logic o_field_rd,
  output logic [hsa_pkg::WORD_W-1:0] o_field_id,
  // answer from the device
  input wire logic i_field_ack,
  input wire logic i_field_bad,
  input wire logic [hsa_pkg::WORD_W-1:0] i_field_data
);
  import hsa_pkg::*;
  // idle request at time zero
  initial begin
    o_field_rd = 1'b0;
    o_field_id = 16'h0000;
  end
  // one read: request stands one cycle, answer taken at the negedge that ends it
  task automatic read_field(input logic [15:0] id, output logic [15:0] data,
      output logic bad, output logic ack);
    @(negedge i_mclk);
    o_field_rd = 1'b1;
    o_field_id = id;
    @(negedge i_mclk);
    o_field_rd = 1'b0;
    o_field_id = ~id; // released id never shows the last value
    ack = i_field_ack;
    bad = i_field_bad;
    data = i_field_data;
  endtask
endmodule // hsa_host_model

// ==== verification/test_health_status_aggregator.sv ====
// self-checking bench for the health status aggregator
// assumes a short persistency filter: threshold 2, leak every 20 cycles
`timescale 1ns/1ps
module test_health_status_aggregator;
  import hsa_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] power_oob = '0;
  logic board_temp = 1'b0;
  logic [4:0] user_flags = '0;
  logic [4:0] aiding_flags = '0;
  logic [2:0] algo_flags = '0;
  logic crc_bad = 1'b0;
  logic nv_write = 1'b0;
  logic revalid = 1'b0;
  logic mag_oob = 1'b0;
  logic [2:0] hw_cond = '0;
  logic store_unlocked = 1'b0;
  logic [15:0] alert_mask = '0;
  logic [2:0] ext_alert = '0;
  logic field_rd, field_ack, field_bad, hw_fault;
  logic [15:0] field_id, field_data;
  int failures = 0;
  int checks = 0;

  // clock at 125 MHz
  always #4 mclk = ~mclk;

  hsa_top #(.PERSIST_CNT_W(8), .PERSIST_THRESHOLD(2), .PERSIST_LEAK_CYCLES(20)) dut (
    .i_mclk(mclk), .i_rst(rst), .i_power_oob(power_oob), .i_board_temp_oob(board_temp),
    .i_user_port_flags(user_flags), .i_aiding_port_flags(aiding_flags),
    .i_algo_flags(algo_flags), .i_cal_crc_mismatch(crc_bad), .i_cal_nv_write(nv_write),
    .i_cal_revalidated(revalid), .i_mag_align_oob(mag_oob), .i_hw_cond(hw_cond),
    .i_cal_store_unlocked(store_unlocked), .i_hw_alert_mask(alert_mask),
    .i_link_alert_summary(ext_alert[0]), .i_sw_alert_summary(ext_alert[1]),
    .i_sensing_alert_summary(ext_alert[2]), .i_field_rd(field_rd), .i_field_id(field_id),
    .o_field_ack(field_ack), .o_field_bad(field_bad), .o_field_data(field_data),
    .o_hw_fault(hw_fault));

  hsa_host_model host (.i_mclk(mclk), .o_field_rd(field_rd), .o_field_id(field_id),
    .i_field_ack(field_ack), .i_field_bad(field_bad), .i_field_data(field_data));

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      failures++;
    end
  endtask

  // read a field, expect a good answer, compare the bits under mask
  task automatic rd(input logic [15:0] id, input logic [15:0] exp, input logic [15:0] msk);
    logic [15:0] d;
    logic b, a;
    host.read_field(id, d, b, a);
    check($sformatf("ack/bad of %h", id), 16'h0002, {14'h0000, a, b});
    check($sformatf("field %h", id), exp, d & msk);
  endtask

  // clear all leaves, then pulse reset
  task automatic do_reset();
    {power_oob, board_temp, user_flags, aiding_flags, algo_flags} = '0;
    {crc_bad, nv_write, revalid, mag_oob, hw_cond, store_unlocked} = '0;
    alert_mask = '0;
    ext_alert = '0;
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(1);
  endtask

  task automatic soft_pulse();
    power_oob = 9'h001;
    step(2);
    power_oob = 9'h000;
    step(2);
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    results();
  end

  initial begin
    logic [15:0] d;
    logic b, a;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    step(1);
    // every field reads zero after reset, unknown id refused
    for (int i = 0; i < 11; i++) rd(16'h0100 + 16'(i), 16'h0000, 16'hffff);
    check("fault after reset", 16'h0000, {15'h0000, hw_fault});
    host.read_field(16'h0200, d, b, a);
    check("unknown id ack/bad", 16'h0003, {14'h0000, a, b});
    check("unknown id data", 16'h0000, d);
    $display("test reset done");
    // supply and ambient flags walk up the tree
    for (int i = 0; i < 9; i++) begin
      power_oob = 9'(1 << i);
      step(2);
      rd(FID_POWER, 16'(1 << i), 16'hffff);
      rd(FID_HW, 16'h0001, 16'hffff);
      rd(FID_GLOBAL, 16'h0002, 16'hfffe);
    end
    power_oob = '0;
    board_temp = 1'b1;
    step(2);
    rd(FID_AMBIENT, 16'h0001, 16'hffff);
    rd(FID_HW, 16'h0002, 16'hffff);
    $display("test hardware errors done");
    // both serial ports walk up the tree
    do_reset();
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 5; i++) begin
        user_flags = (p == 0) ? 5'(1 << i) : 5'h00;
        aiding_flags = (p == 1) ? 5'(1 << i) : 5'h00;
        step(2);
        rd((p == 0) ? FID_USER : FID_AIDING, 16'(1 << i), 16'hffff);
        rd(FID_LINK, 16'(1 << p), 16'hffff);
        rd(FID_GLOBAL, 16'h0004, 16'hfffe);
      end
    end
    $display("test link errors done");
    // soft error is fatal only when it recurs inside the window
    do_reset();
    soft_pulse();
    rd(FID_HW, 16'h0000, 16'hffff);
    step(60);
    soft_pulse();
    step(4);
    check("fault on sparse soft", 16'h0000, {15'h0000, hw_fault});
    step(60);
    repeat (3) soft_pulse();
    step(4);
    check("fault on recurring soft", 16'h0001, {15'h0000, hw_fault});
    rd(FID_GLOBAL, 16'h0001, 16'h000f);
    // recurring serial port errors trip the link filter
    do_reset();
    repeat (3) begin
      user_flags = 5'h01;
      step(2);
      user_flags = 5'h00;
      step(2);
    end
    check("fault on recurring link", 16'h0001, {15'h0000, hw_fault});
    $display("test persistency done");
    // hard flags set the fatal bit two cycles later, without the filter
    do_reset();
    algo_flags = 3'h1;
    step(1);
    check("fault one cycle", 16'h0000, {15'h0000, hw_fault});
    step(1);
    check("fault two cycles", 16'h0001, {15'h0000, hw_fault});
    for (int i = 0; i < 3; i++) begin
      algo_flags = 3'(1 << i);
      step(2);
      rd(FID_ALGO, 16'(1 << i), 16'hffff);
      rd(FID_SW, 16'h0001, 16'hffff);
      rd(FID_GLOBAL, 16'h0009, 16'hffff);
    end
    $display("test algorithm errors done");
    // stored data flags and the compromise latch
    do_reset();
    crc_bad = 1'b1;
    step(2);
    rd(FID_DATA, 16'h0001, 16'hffff);
    crc_bad = 1'b0;
    mag_oob = 1'b1;
    step(2);
    rd(FID_DATA, 16'h0002, 16'hffff);
    rd(FID_SW, 16'h0002, 16'hffff);
    mag_oob = 1'b0;
    nv_write = 1'b1;
    step(1);
    nv_write = 1'b0;
    step(6);
    rd(FID_DATA, 16'h0001, 16'hffff);
    revalid = 1'b1;
    step(1);
    revalid = 1'b0;
    step(1);
    rd(FID_DATA, 16'h0000, 16'hffff);
    {nv_write, revalid} = 2'b11;
    step(1);
    {nv_write, revalid} = 2'b00;
    step(1);
    rd(FID_DATA, 16'h0001, 16'hffff);
    $display("test data errors done");
    // condition word, enable mask and alert summaries
    do_reset();
    for (int i = 0; i < 3; i++) begin
      hw_cond = 3'(1 << i);
      alert_mask = 16'h0000;
      step(2);
      rd(FID_COND, 16'(1 << i), 16'hffff);
      rd(FID_GLOBAL, 16'h0000, 16'hff00);
      alert_mask = 16'hffff;
      step(2);
      rd(FID_GLOBAL, 16'h0300, 16'hff00);
    end
    hw_cond = '0;
    store_unlocked = 1'b1;
    alert_mask = 16'h0007;
    step(2);
    rd(FID_COND, 16'h0008, 16'hffff);
    rd(FID_GLOBAL, 16'h0000, 16'hff00);
    alert_mask = 16'h0008;
    step(2);
    rd(FID_GLOBAL, 16'h0300, 16'hff00);
    store_unlocked = 1'b0;
    alert_mask = '0;
    for (int j = 0; j < 3; j++) begin
      ext_alert = 3'(1 << j);
      step(2);
      rd(FID_GLOBAL, 16'h0100 | 16'(1 << (10 + j)), 16'hff00);
    end
    $display("test alerts done");
    results();
  end
endmodule // test_health_status_aggregator
